//--- verilog/awg_pkg.sv
package awg_pkg;
	// system clock rate and derived divider for the fixed 1 MHz source
	localparam int CLK_HZ = 40_000_000;
	localparam int ONE_MHZ_HZ = 1_000_000;
	localparam int ONE_MHZ_DIV = CLK_HZ / ONE_MHZ_HZ;
	localparam int DIV_W = 6;
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(ONE_MHZ_DIV - 1);
	// local programmable clock: rate in hertz, accumulator against CLK_HZ
	localparam int RATE_W = 20;
	localparam int ACC_W = 27;
	localparam logic [RATE_W-1:0] LOCAL_RATE_MAX_HZ = 20'hbe6e0;
	localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(CLK_HZ);
	// sample memory geometry
	localparam int NUM_CH = 2;
	localparam int NUM_BANKS = 4;
	localparam int BANK_W = 2;
	localparam int BANK_DEPTH = 8192;
	localparam int ADDR_W = 13;
	localparam int SAMPLE_W = 12;
	localparam int GAIN_W = 16;
	localparam logic [ADDR_W-1:0] ADDR_LAST = 13'h1fff;
	// phase: degrees, 0..720 each, scaled to sample slots (8192/720 in q10)
	localparam int DEG_W = 10;
	localparam int PSUM_W = 11;
	localparam int PSCALE_W = 14;
	localparam int PROD_W = 25;
	localparam int PHASE_SHIFT = 10;
	localparam logic [PSCALE_W-1:0] PHASE_SCALE = 14'h2d83;
	// trigger origin codes
	localparam int TRIG_W = 4;
	localparam int EXT_TRIG_N = 4;
	localparam logic [TRIG_W-1:0] TRIG_SPEED = 4'h0;
	localparam logic [TRIG_W-1:0] TRIG_EXT0 = 4'h1;
	localparam logic [TRIG_W-1:0] TRIG_EXT1 = 4'h2;
	localparam logic [TRIG_W-1:0] TRIG_EXT2 = 4'h3;
	localparam logic [TRIG_W-1:0] TRIG_EXT3 = 4'h4;
	localparam logic [TRIG_W-1:0] TRIG_NONE = 4'ha;
	localparam logic [TRIG_W-1:0] TRIG_ANY_EXT = 4'hc;
	// sample clock origin codes
	localparam int CSRC_W = 3;
	localparam int EXT_CLK_N = 2;
	localparam logic [CSRC_W-1:0] CSRC_1MHZ = 3'h0;
	localparam logic [CSRC_W-1:0] CSRC_LOCAL = 3'h1;
	localparam logic [CSRC_W-1:0] CSRC_EXT1 = 3'h2;
	localparam logic [CSRC_W-1:0] CSRC_EXT2 = 3'h3;
	localparam logic [CSRC_W-1:0] CSRC_SPEED = 3'h4;
	// trigger behaviour: zero means continuous
	localparam int TBEH_W = 8;
	localparam logic [TBEH_W-1:0] TBEH_CONT = 8'h00;
	// playback states
	typedef enum logic [1:0] {
		ST_HOLD = 2'b01,
		ST_PLAY = 2'b10
	} play_state_t;
	// per-channel settings from the model
	typedef struct packed {
		logic [BANK_W-1:0] bank_select;
		logic [GAIN_W-1:0] output_gain;
		logic output_stage_kind;
		logic reference_select;
		logic ground_select;
		logic channel_output_on;
		logic [DEG_W-1:0] runtime_phase_offset;
	} chan_cfg_t;
	// per-channel analog stage controls
	typedef struct packed {
		logic [GAIN_W-1:0] gain;
		logic analog_oe;
		logic oc_oe;
		logic ref_external;
		logic gnd_battery;
	} chan_stage_t;
	// bank loading port
	typedef struct packed {
		logic en;
		logic ch;
		logic [BANK_W-1:0] bank;
		logic [ADDR_W-1:0] addr;
		logic [SAMPLE_W-1:0] data;
	} bank_wr_t;
endpackage

//--- verilog/awg_top.sv

// two-entry buffer between playback and the converter
module awg_sbuf #(
	parameter int W = 8
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready
);
	logic [W-1:0] d0_ff; // head entry
	logic [W-1:0] d1_ff; // second entry
	logic v0_ff; // head valid
	logic v1_ff; // second valid
	logic pop;
	logic push;

	assign pop = v0_ff & out_ready;
	assign push = in_valid & ~v1_ff;
	assign in_ready = ~v1_ff;
	assign out_valid = v0_ff;
	assign out_data = d0_ff;

	// entry shift and fill
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			v0_ff <= 1'b0;
			v1_ff <= 1'b0;
			d0_ff <= '0;
			d1_ff <= '0;
		end else if (pop) begin
			// head leaves, second moves up or new word lands in head
			v0_ff <= v1_ff | push;
			v1_ff <= 1'b0;
			// with nothing behind it the head keeps its word as the held level
			if (v1_ff) begin
				d0_ff <= d1_ff;
			end else if (push) begin
				d0_ff <= in_data;
			end
		end else if (push) begin
			if (!v0_ff) begin
				v0_ff <= 1'b1;
				d0_ff <= in_data;
			end else begin
				v1_ff <= 1'b1;
				d1_ff <= in_data;
			end
		end
	end
endmodule

// one playback channel with its own sample banks
module awg_channel (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire awg_pkg::chan_cfg_t cfg,
	input wire logic [awg_pkg::DEG_W-1:0] global_phase,
	input wire logic wait_mode,
	input wire logic trig_ev,
	input wire logic smp_tick,
	input wire awg_pkg::bank_wr_t wr,
	input wire logic my_ch,
	input wire logic out_ready,
	output logic out_valid,
	output logic [awg_pkg::SAMPLE_W-1:0] out_sample,
	output awg_pkg::chan_stage_t stage
);
	import awg_pkg::*;

	logic [SAMPLE_W-1:0] mem [0:NUM_BANKS*BANK_DEPTH-1]; // four banks back to back
	play_state_t state_ff; // hold or play
	logic [ADDR_W-1:0] cnt_ff; // playback counter
	logic [BANK_W-1:0] bank_ff; // bank taken at trigger
	logic [ADDR_W-1:0] start_ff; // phase start slot taken at trigger
	logic [SAMPLE_W-1:0] rd_data_ff; // fetched sample
	logic push_ff; // fetched sample is ready for the buffer
	chan_stage_t stage_ff; // registered stage controls
	logic buf_ready; // buffer has room
	logic room_next; // buffer will take a word at the next edge
	logic take_trig; // trigger accepted this cycle
	logic step; // counter advances this cycle
	logic [PSUM_W-1:0] phase_sum; // global plus runtime degrees
	logic [PROD_W-1:0] phase_prod; // degrees times slots per degree
	logic [ADDR_W-1:0] nxt_start; // start slot from current phase
	logic [ADDR_W-1:0] slot; // slot inside bank

	// phase in degrees to a slot, wrapping modulo the bank size
	assign phase_sum = PSUM_W'(global_phase) + PSUM_W'(cfg.runtime_phase_offset);
	assign phase_prod = PROD_W'(phase_sum) * PROD_W'(PHASE_SCALE);
	assign nxt_start = phase_prod[PHASE_SHIFT +: ADDR_W];
	assign slot = start_ff + cnt_ff;

	// wait mode ignores triggers while a pass is running
	assign take_trig = trig_ev & (~wait_mode | (state_ff == ST_HOLD));
	// a fetched word reaches the buffer one edge later, so room is judged for then:
	// a pop frees it, otherwise a pending push must not fill the second entry
	assign room_next = (out_valid & out_ready) | (buf_ready & ~(push_ff & out_valid));
	// a sample clock edge is used only when the buffer can take the word
	assign step = smp_tick & room_next & (state_ff == ST_PLAY);

	// bank loading from the model
	always_ff @(posedge clk_sys) begin
		if (wr.en && (wr.ch == my_ch)) begin
			mem[{wr.bank, wr.addr}] <= wr.data;
		end
	end

	// bank and phase are taken only at an accepted trigger
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			bank_ff <= '0;
			start_ff <= '0;
		end else if (take_trig) begin
			bank_ff <= cfg.bank_select;
			start_ff <= nxt_start;
		end
	end

	// playback state and counter
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			state_ff <= ST_HOLD;
			cnt_ff <= '0;
		end else if (take_trig) begin
			// restart from the first sample
			state_ff <= ST_PLAY;
			cnt_ff <= '0;
		end else begin
			unique case (state_ff)
				ST_HOLD: begin
					// continuous mode never rests
					if (!wait_mode) begin
						state_ff <= ST_PLAY;
						cnt_ff <= '0;
					end
				end
				ST_PLAY: begin
					if (step) begin
						if (cnt_ff == ADDR_LAST) begin
							cnt_ff <= '0;
							// wait mode rests on the last level
							if (wait_mode) begin
								state_ff <= ST_HOLD;
							end
						end else begin
							cnt_ff <= cnt_ff + 1'b1;
						end
					end
				end
			endcase
		end
	end

	// sample fetch from the selected bank
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			rd_data_ff <= '0;
			push_ff <= 1'b0;
		end else begin
			push_ff <= step;
			if (step) begin
				rd_data_ff <= mem[{bank_ff, slot}];
			end
		end
	end

	// stage controls follow settings directly
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			stage_ff <= '0;
		end else begin
			stage_ff.gain <= cfg.output_gain;
			stage_ff.analog_oe <= cfg.channel_output_on & cfg.output_stage_kind;
			stage_ff.oc_oe <= cfg.channel_output_on & ~cfg.output_stage_kind;
			stage_ff.ref_external <= cfg.reference_select;
			stage_ff.gnd_battery <= cfg.ground_select;
		end
	end

	assign stage = stage_ff;

	// buffer toward the converter; holds the last word until replaced
	awg_sbuf #(
		.W(SAMPLE_W)
	) u_buf (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.in_valid(push_ff),
		.in_data(rd_data_ff),
		.in_ready(buf_ready),
		.out_valid(out_valid),
		.out_data(out_sample),
		.out_ready(out_ready)
	);
endmodule

// two-channel generator with shared trigger and sample clock
module awg_top #(
	parameter logic [awg_pkg::DEG_W-1:0] GLOBAL_PHASE_0 = 10'h000,
	parameter logic [awg_pkg::DEG_W-1:0] GLOBAL_PHASE_1 = 10'h000
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire awg_pkg::chan_cfg_t [awg_pkg::NUM_CH-1:0] ch_cfg,
	input wire logic [awg_pkg::TRIG_W-1:0] trigger_origin,
	input wire logic [awg_pkg::CSRC_W-1:0] sample_clock_origin,
	input wire logic [awg_pkg::RATE_W-1:0] local_clock_rate,
	input wire logic [awg_pkg::TBEH_W-1:0] trigger_behaviour,
	input wire logic speed_trig,
	input wire logic speed_tick,
	input wire logic [awg_pkg::EXT_TRIG_N-1:0] ext_trig,
	input wire logic [awg_pkg::EXT_CLK_N-1:0] ext_clk,
	input wire awg_pkg::bank_wr_t bank_wr,
	input wire logic [awg_pkg::NUM_CH-1:0] smp_ready,
	output logic [awg_pkg::NUM_CH-1:0] smp_valid,
	output logic [awg_pkg::NUM_CH-1:0][awg_pkg::SAMPLE_W-1:0] smp_data,
	output awg_pkg::chan_stage_t [awg_pkg::NUM_CH-1:0] ch_stage
);
	import awg_pkg::*;

	logic [EXT_TRIG_N-1:0] ext_trig_prev_ff; // previous external trigger levels
	logic [EXT_CLK_N-1:0] ext_clk_prev_ff; // previous external clock levels
	logic [DIV_W-1:0] div_ff; // 1 MHz divider
	logic tick_1mhz; // 1 MHz tick
	logic [ACC_W-1:0] acc_ff; // local clock accumulator
	logic [RATE_W-1:0] rate_lim; // rate clipped to its top
	logic [ACC_W-1:0] acc_sum; // accumulator plus rate
	logic tick_local; // local clock tick
	logic [EXT_TRIG_N-1:0] ext_trig_rise; // external trigger edges
	logic [EXT_CLK_N-1:0] ext_clk_rise; // external clock edges
	logic trig_ev; // shared trigger event
	logic smp_tick; // shared sample clock tick
	logic wait_mode; // wait for trigger selected

	// edge detection on the synchronous external pins
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			ext_trig_prev_ff <= '0;
			ext_clk_prev_ff <= '0;
		end else begin
			ext_trig_prev_ff <= ext_trig;
			ext_clk_prev_ff <= ext_clk;
		end
	end

	assign ext_trig_rise = ext_trig & ~ext_trig_prev_ff;
	assign ext_clk_rise = ext_clk & ~ext_clk_prev_ff;

	// fixed 1 MHz source from the system clock
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			div_ff <= '0;
		end else if (div_ff == DIV_LAST) begin
			div_ff <= '0;
		end else begin
			div_ff <= div_ff + 1'b1;
		end
	end

	assign tick_1mhz = (div_ff == DIV_LAST);

	// local clock: rate added each cycle, one tick per wrap of CLK_HZ
	assign rate_lim = (local_clock_rate > LOCAL_RATE_MAX_HZ) ? LOCAL_RATE_MAX_HZ
		: local_clock_rate;
	assign acc_sum = acc_ff + ACC_W'(rate_lim);
	assign tick_local = (acc_sum >= ACC_WRAP);

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			acc_ff <= '0;
		end else if (tick_local) begin
			acc_ff <= acc_sum - ACC_WRAP;
		end else begin
			acc_ff <= acc_sum;
		end
	end

	// shared trigger multiplexer; unused codes give no trigger
	always_comb begin
		unique case (trigger_origin)
			TRIG_SPEED: trig_ev = speed_trig;
			TRIG_EXT0: trig_ev = ext_trig_rise[0];
			TRIG_EXT1: trig_ev = ext_trig_rise[1];
			TRIG_EXT2: trig_ev = ext_trig_rise[2];
			TRIG_EXT3: trig_ev = ext_trig_rise[3];
			TRIG_ANY_EXT: trig_ev = |ext_trig_rise;
			TRIG_NONE: trig_ev = 1'b0;
			default: trig_ev = 1'b0;
		endcase
	end

	// shared sample clock multiplexer; unused codes stop the clock
	always_comb begin
		unique case (sample_clock_origin)
			CSRC_1MHZ: smp_tick = tick_1mhz;
			CSRC_LOCAL: smp_tick = tick_local;
			CSRC_EXT1: smp_tick = ext_clk_rise[0];
			CSRC_EXT2: smp_tick = ext_clk_rise[1];
			CSRC_SPEED: smp_tick = speed_tick;
			default: smp_tick = 1'b0;
		endcase
	end

	assign wait_mode = (trigger_behaviour != TBEH_CONT);

	// identical channels share trigger, clock and mode
	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		awg_channel u_ch (
			.clk_sys(clk_sys),
			.rstn(rstn),
			.cfg(ch_cfg[c]),
			.global_phase((c == 0) ? GLOBAL_PHASE_0 : GLOBAL_PHASE_1),
			.wait_mode(wait_mode),
			.trig_ev(trig_ev),
			.smp_tick(smp_tick),
			.wr(bank_wr),
			.my_ch(1'(c)),
			.out_ready(smp_ready[c]),
			.out_valid(smp_valid[c]),
			.out_sample(smp_data[c]),
			.stage(ch_stage[c])
		);
	end
endmodule

//--- bench/awg_top_monitor.sv
// watches generator ports: stage controls and the sample stream
module awg_top_monitor (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire awg_pkg::chan_cfg_t [awg_pkg::NUM_CH-1:0] ch_cfg,
	input wire logic [awg_pkg::CSRC_W-1:0] sample_clock_origin,
	input wire logic [awg_pkg::RATE_W-1:0] local_clock_rate,
	input wire logic [awg_pkg::NUM_CH-1:0] smp_ready,
	input wire logic [awg_pkg::NUM_CH-1:0] smp_valid,
	input wire logic [awg_pkg::NUM_CH-1:0][awg_pkg::SAMPLE_W-1:0] smp_data,
	input wire awg_pkg::chan_stage_t [awg_pkg::NUM_CH-1:0] ch_stage
);
	timeunit 1ns;
	timeprecision 1ps;
	import awg_pkg::*;
	// one clock domain, checks paused in reset
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	// analog enable is output on and analog kind, one cycle later
	property p_oe0;
		$past(rstn) |-> ch_stage[0].analog_oe ==
			$past(ch_cfg[0].channel_output_on && ch_cfg[0].output_stage_kind);
	endproperty
	a_oe0: assert property (p_oe0) else $error("ch0 analog enable wrong");
	// a channel switched off drives neither stage
	property p_off0;
		!ch_cfg[0].channel_output_on ##1 1'b1 |-> !ch_stage[0].analog_oe && !ch_stage[0].oc_oe;
	endproperty
	a_off0: assert property (p_off0) else $error("ch0 not high impedance");
	// reference choice passes straight to the stage
	property p_ref0;
		$past(rstn) |-> ch_stage[0].ref_external == $past(ch_cfg[0].reference_select);
	endproperty
	a_ref0: assert property (p_ref0) else $error("ch0 reference wrong");
	// ground choice reaches the stage on the next edge
	property p_gnd0;
		$rose(ch_cfg[0].ground_select) |=> ch_stage[0].gnd_battery;
	endproperty
	a_gnd0: assert property (p_gnd0) else $error("ch0 ground wrong");
	// new gain code appears one cycle later
	property p_gain0;
		$changed(ch_cfg[0].output_gain) |=> ch_stage[0].gain == $past(ch_cfg[0].output_gain);
	endproperty
	a_gain0: assert property (p_gain0) else $error("ch0 gain wrong");
	// channel one decodes its own stage kind
	property p_oe1;
		ch_cfg[1].channel_output_on && !ch_cfg[1].output_stage_kind
			|=> ch_stage[1].oc_oe && !ch_stage[1].analog_oe;
	endproperty
	a_oe1: assert property (p_oe1) else $error("ch1 switch enable wrong");
	// a stalled word stays put until taken
	property p_hold0;
		smp_valid[0] && !smp_ready[0] |=> smp_valid[0] && $stable(smp_data[0]);
	endproperty
	a_hold0: assert property (p_hold0) else $error("ch0 word lost in stall");
	// local clock at zero rate makes no new words
	property p_rate0;
		(sample_clock_origin == CSRC_LOCAL && local_clock_rate == 20'h00000)[*6]
			|-> !$rose(smp_valid[0]);
	endproperty
	a_rate0: assert property (p_rate0) else $error("word at zero rate");
endmodule

//--- bench/awg_sink.sv
// converter side: takes words, stalling every other cycle when slow
module awg_sink (
	input wire logic clk_sys,
	input wire logic slow,
	input wire logic [awg_pkg::NUM_CH-1:0] smp_valid,
	input wire logic [awg_pkg::NUM_CH-1:0][awg_pkg::SAMPLE_W-1:0] smp_data,
	output logic [awg_pkg::NUM_CH-1:0] smp_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	import awg_pkg::*;
	logic [SAMPLE_W-1:0] q0[$]; // words taken on channel 0
	logic [SAMPLE_W-1:0] q1[$]; // words taken on channel 1
	logic rdy_ff = 1'b1;
	// ready moves only just after an edge
	always @(posedge clk_sys) rdy_ff <= slow ? ~rdy_ff : 1'b1;
	assign smp_ready = {NUM_CH{rdy_ff}};
	// a word moves where valid and ready meet at an edge
	always @(posedge clk_sys) begin
		if (smp_valid[0] && smp_ready[0]) q0.push_back(smp_data[0]);
		if (smp_valid[1] && smp_ready[1]) q1.push_back(smp_data[1]);
	end
endmodule

//--- bench/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import awg_pkg::*;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	chan_cfg_t [NUM_CH-1:0] ch_cfg = '0;
	logic [TRIG_W-1:0] trigger_origin = TRIG_NONE;
	logic [CSRC_W-1:0] sample_clock_origin = CSRC_SPEED;
	logic [RATE_W-1:0] local_clock_rate = '0;
	logic [TBEH_W-1:0] trigger_behaviour = 8'h80; // nonzero: wait
	logic speed_trig = 1'b0;
	logic speed_tick = 1'b0;
	logic [EXT_TRIG_N-1:0] ext_trig = '0;
	logic [EXT_CLK_N-1:0] ext_clk = '0; // external clocks idle
	bank_wr_t bank_wr = '0;
	logic slow = 1'b0;
	logic [NUM_CH-1:0] smp_ready;
	logic [NUM_CH-1:0] smp_valid;
	logic [NUM_CH-1:0][SAMPLE_W-1:0] smp_data;
	chan_stage_t [NUM_CH-1:0] ch_stage;
	int n_fail = 0;
	int n_tests = 0;
	int slot;
	int slot1;
	// channel 1 sits 180 degrees ahead so the global phase is exercised
	awg_top #(.GLOBAL_PHASE_1(10'h0b4)) awg_top_i (.clk_sys, .rstn, .ch_cfg,
		.trigger_origin, .sample_clock_origin, .local_clock_rate, .trigger_behaviour,
		.speed_trig, .speed_tick, .ext_trig, .ext_clk, .bank_wr, .smp_ready, .smp_valid,
		.smp_data, .ch_stage);
	awg_sink awg_sink_i (.clk_sys, .slow, .smp_valid, .smp_data, .smp_ready);
	// 40 MHz system clock
	initial forever #12.5 clk_sys = ~clk_sys;
	// sample pattern stored at each bank slot
	function automatic logic [SAMPLE_W-1:0] fill(input logic [1:0] b, input int a);
		return a[11:0] ^ {6{b}} ^ {a[12], 11'h000};
	endfunction
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	// reset for two cycles and forget captured words
	task automatic do_reset();
		rstn = 1'b0;
		cyc(2);
		rstn = 1'b1;
		cyc(1);
		awg_sink_i.q0.delete();
		awg_sink_i.q1.delete();
	endtask
	task automatic pulse(input logic spd, input logic [3:0] ext);
		speed_trig = spd;
		ext_trig = ext;
		cyc(1);
		speed_trig = 1'b0;
		ext_trig = '0;
		cyc(1);
	endtask
	task automatic ticks(input int n);
		speed_tick = 1'b1;
		cyc(n);
		speed_tick = 1'b0;
		cyc(6);
	endtask
	// bounded wait for channel 0 words
	task automatic wait_words(input int n);
		int i;
		for (i = 0; i < 60000 && awg_sink_i.q0.size() < n; i++) cyc(1);
		if (awg_sink_i.q0.size() < n) begin
			n_fail++;
			final_report();
		end
	endtask
	// ch0 banks 1 and 2, ch1 bank 2
	task automatic load();
		for (int k = 0; k < 3 * BANK_DEPTH; k++) begin
			bank_wr = {1'b1, k >= 2 * BANK_DEPTH, k < BANK_DEPTH ? 2'h1 : 2'h2,
				k[ADDR_W-1:0], fill(k < BANK_DEPTH ? 2'h1 : 2'h2, k % BANK_DEPTH)};
			cyc(1);
		end
		bank_wr = '0;
	endtask
	task automatic t_stage();
		chan_stage_t e;
		for (int i = 0; i < 16; i++) begin
			ch_cfg[0] = {2'h0, 16'h1111 * i[15:0], i[0], i[1], i[2], i[3], 10'h000};
			ch_cfg[1] = ch_cfg[0];
			ch_cfg[1].output_stage_kind = ~i[0];
			cyc(2);
			e = {ch_cfg[0].output_gain, i[3] & i[0], i[3] & ~i[0], i[1], i[2]};
			check("stage0", ch_stage[0], e);
			e.analog_oe = i[3] & ~i[0];
			e.oc_oe = i[3] & i[0];
			check("stage1", ch_stage[1], e);
		end
		$display("stage test done");
	endtask
	// each trigger code, first with every other source pulsed
	task automatic t_trig();
		logic [3:0] codes [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'hc, 4'ha, 4'h5};
		logic [3:0] c;
		logic [3:0] sel;
		foreach (codes[j]) begin
			c = codes[j];
			sel = (c >= 4'h1 && c <= 4'h4) ? 4'h1 << (c - 4'h1) : (c == 4'hc ? 4'h4 : 4'h0);
			trigger_origin = c;
			do_reset();
			pulse(c != 4'h0, c == 4'hc ? 4'h0 : ~sel);
			ticks(1);
			check("stray start", awg_sink_i.q0.size(), 0);
			pulse(c == 4'h0, sel);
			ticks(1);
			check("start", awg_sink_i.q0.size(), c != 4'ha && c != 4'h5);
		end
		$display("trigger test done");
	endtask
	task automatic t_wait();
		trigger_origin = TRIG_EXT0;
		ch_cfg[0].bank_select = 2'h1;
		ch_cfg[0].runtime_phase_offset = 10'h05a;
		ch_cfg[1].bank_select = 2'h2;
		ch_cfg[1].runtime_phase_offset = 10'h05a;
		slot = (90 * int'(PHASE_SCALE)) >> PHASE_SHIFT;
		slot1 = ((180 + 90) * int'(PHASE_SCALE)) >> PHASE_SHIFT;
		do_reset();
		slow = 1'b1;
		pulse(1'b0, 4'h1);
		speed_tick = 1'b1;
		cyc(100);
		ch_cfg[0].bank_select = 2'h2; // must wait for the next trigger
		wait_words(BANK_DEPTH);
		cyc(60);
		check("word count", awg_sink_i.q0.size(), BANK_DEPTH);
		check("held level", smp_data[0], fill(2'h1, slot - 1));
		for (int k = 0; k < BANK_DEPTH; k++) begin
			check("ch0 word", awg_sink_i.q0[k], fill(2'h1, (slot + k) % BANK_DEPTH));
			check("ch1 word", awg_sink_i.q1[k], fill(2'h2, (slot1 + k) % BANK_DEPTH));
		end
		awg_sink_i.q0.delete();
		pulse(1'b0, 4'h1);
		wait_words(2);
		check("new bank", awg_sink_i.q0[0], fill(2'h2, slot));
		speed_tick = 1'b0;
		slow = 1'b0;
		$display("wait test done");
	endtask
	task automatic t_cont();
		trigger_behaviour = TBEH_CONT;
		trigger_origin = TRIG_EXT1;
		ch_cfg[0].bank_select = 2'h1;
		ch_cfg[0].runtime_phase_offset = '0;
		do_reset();
		pulse(1'b0, 4'h2);
		speed_tick = 1'b1;
		wait_words(BANK_DEPTH + 8);
		speed_tick = 1'b0;
		for (int k = 0; k < 8; k++)
			check("wrap", awg_sink_i.q0[BANK_DEPTH + k], fill(2'h1, k));
		cyc(10);
		awg_sink_i.q0.delete();
		pulse(1'b0, 4'h2);
		ticks(2);
		check("restart", awg_sink_i.q0[0], fill(2'h1, 0));
		$display("continuous test done");
	endtask
	// word counts over 2000 cycles per clock origin; ext clocks run at periods 40 and 80
	task automatic t_clk();
		logic [CSRC_W-1:0] org [7] = '{CSRC_1MHZ, CSRC_LOCAL, CSRC_LOCAL, CSRC_LOCAL, 3'h5,
			CSRC_EXT1, CSRC_EXT2};
		logic [RATE_W-1:0] rate [7] = '{20'h0, 20'h61a80, 20'hfffff, 20'h0, 20'h0, 20'h0, 20'h0};
		int e;
		int n;
		foreach (org[j]) begin
			sample_clock_origin = org[j];
			local_clock_rate = rate[j];
			do_reset();
			for (int t = 0; t < 2000; t++) begin
				ext_clk = {(t % 80) < 40, (t % 40) < 20};
				cyc(1);
			end
			ext_clk = '0;
			n = awg_sink_i.q0.size();
			e = org[j] == CSRC_1MHZ ? 2000 / ONE_MHZ_DIV : org[j] == CSRC_EXT1 ? 50 :
				org[j] == CSRC_EXT2 ? 25 : org[j] != CSRC_LOCAL ? 0 :
				int'(rate[j] > LOCAL_RATE_MAX_HZ ? LOCAL_RATE_MAX_HZ : rate[j]) * 2000 / CLK_HZ;
			check("tick count", n >= e - 1 && n <= e + 1, 1);
		end
		$display("clock test done");
	endtask
	initial begin
		do_reset();
		load();
		t_stage();
		t_trig();
		t_wait();
		t_cont();
		t_clk();
		final_report();
	end
	// cut a hang short
	initial begin
		repeat (90000) @(posedge clk_sys);
		n_fail++;
		final_report();
	end
endmodule
bind awg_top awg_top_monitor awg_top_monitor_i (.clk_sys, .rstn, .ch_cfg,
	.sample_clock_origin, .local_clock_rate, .smp_ready, .smp_valid, .smp_data, .ch_stage);
